// >>> nvm_map.vh
// Purpose: constants for the eeprom program/erase control block
// Assumes: 16-bit cpu addresses, 8-bit data
// Notes:   included by both design files
`ifndef NVM_MAP_VH
`define NVM_MAP_VH
`define ARRAY_BASE     16'h0800
`define ARRAY_LAST     16'h09ff
`define SECURE_FIRST   16'h08f0
`define SECURE_LAST    16'h08ff
`define NVCFG_ADDR     16'hfe1c
`define SHADOW_ADDR    16'hfe1f
`define CTRL_ADDR      16'hfe1d
`define CTRL_HV_BIT    0
`define CTRL_LAT_BIT   1
`define CTRL_ERLO_BIT  2
`define CTRL_ERHI_BIT  3
`define CFG_SEC_BIT    4
`define NVCFG_INIT     8'hff
`define MODE_PROGRAM   2'b00
`define MODE_BYTE_ERA  2'b01
`define MODE_BLOCK_ERA 2'b10
`define MODE_BULK_ERA  2'b11
`endif

// >>> nvm_array.v
// Purpose: behavioural 512-byte array plus non-volatile config byte
// Assumes: one operation per high-voltage pulse, applied on its rise
// Notes:   programming only clears bits, erase sets them to one
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_array #(
  parameter DEPTH = 512
) (
  input  wire       clk_sys,
  input  wire       apply,
  input  wire [1:0] mode,
  input  wire [8:0] addr,
  input  wire       is_cfg,
  input  wire [8:0] keep_mask_blk,
  input  wire [7:0] wdata,
  input  wire [8:0] raddr,
  output reg  [7:0] rdata,
  output reg  [7:0] cfg_byte
);
  reg [7:0] mem [0:DEPTH-1];
  integer i;

  ////////////////////////////////////////////////////////////////////
  // start erased; config byte is not touched by reset
  initial begin
    for (i = 0; i < DEPTH; i = i + 1)
      mem[i] = 8'hff;
    cfg_byte = `NVCFG_INIT;
  end

  // read is combinational; the controller registers the answer
  always @* begin
    rdata = mem[raddr];
  end

  // block/bulk skip the config byte and protected blocks
  always @(posedge clk_sys) begin
    if (apply) begin
      if (is_cfg) begin
        if (mode == `MODE_PROGRAM)
          cfg_byte <= cfg_byte & wdata;
        else if (mode == `MODE_BYTE_ERA)
          cfg_byte <= 8'hff;
      end else begin
        case (mode)
          `MODE_PROGRAM: mem[addr] <= mem[addr] & wdata;
          `MODE_BYTE_ERA: mem[addr] <= 8'hff;
          default: begin
            for (i = 0; i < DEPTH; i = i + 1)
              if ((mode == `MODE_BULK_ERA) ||
                  (i[8:7] == addr[8:7]))
                if (!keep_mask_blk[i[8:7]])
                  mem[i] <= 8'hff;
          end
        endcase
      end
    end
  end
endmodule // nvm_array

// >>> nvm_ctrl.v
// Purpose: eeprom program/erase control, latch, protection, security
// Assumes: single-cycle cpu bus, read data one cycle after read strobe
// Notes:   the array itself is behavioural; hv pulse applies the op
//
// Function
// - latch captures only valid writes, last wins
// - reads of other locations return latched data
// - control writes with latch set need a prior valid write
// - refuse hv when latch clear after foreign write
// - hv bit drives pump and voltage
// - clearing hv and latch together clears hv
// - erase only unprotected valid bytes and config
// - block/bulk clear range, spare config byte
// - protect bit blocks erase; bulk then void
// - erase mode frozen while hv set
// - four 128-byte blocks over 0x0800-0x09ff
// - protected target never gets high voltage
// - protect changes apply after reset or read
// - shadow reloads on reset and config read
// - config byte programmable like array byte
// - security bit zero locks 0x08f0-0x08ff
// - security disables block, bulk, config writes
// - security keeps byte erase and reads
// - secured-location writes are not valid
// - security permanent, config frozen
// - mode encoding; protect forces no operation
// - latch held while hv set; reset clears
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_ctrl (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  output reg         pump_on,
  output reg         hv_applied,
  output reg         secured
);
  // control register bits
  reg        hv_enable;
  reg        latch_enable;
  reg        erase_select_hi;
  reg        erase_select_lo;
  // capture state of the program/erase sequence
  reg        have_valid;
  reg        foreign_write;
  reg [8:0]  lat_addr;
  reg        lat_cfg;
  reg [7:0]  lat_data;
  // configuration shadow and security
  reg [7:0]  config_shadow_reg;
  reg        sec_armed;
  reg        load_pend;
  reg        hv_q;
  // next values, worked out combinationally
  reg        next_hv_enable;
  reg        next_latch_enable;
  reg        next_erase_hi;
  reg        next_erase_lo;
  reg        next_have_valid;
  reg        next_foreign_write;
  reg [7:0]  next_shadow;
  reg        next_sec_armed;
  wire [7:0] arr_rdata;
  wire [7:0] nonvolatile_config_byte;

  // read source codes, shared by decode and answer mux
  localparam [2:0] SRC_NONE  = 3'h0;
  localparam [2:0] SRC_CTRL  = 3'h1;
  localparam [2:0] SRC_SHAD  = 3'h2;
  localparam [2:0] SRC_LATCH = 3'h3;
  localparam [2:0] SRC_NVCFG = 3'h4;
  localparam [2:0] SRC_ARRAY = 3'h5;

  ////////////////////////////////////////////////////////////////////
  // address decode
  function in_array;
    input [15:0] a;
    begin
      in_array = (a >= `ARRAY_BASE) && (a <= `ARRAY_LAST);
    end
  endfunction

  function in_secure;
    input [15:0] a;
    begin
      in_secure = (a >= `SECURE_FIRST) && (a <= `SECURE_LAST);
    end
  endfunction

  // what a read of address a returns, given the latch state
  function [2:0] read_source;
    input [15:0] a;
    input        lat;
    begin
      if (a == `CTRL_ADDR)
        read_source = SRC_CTRL;
      else if (a == `SHADOW_ADDR)
        read_source = SRC_SHAD;
      else if ((in_array(a) || (a == `NVCFG_ADDR)) && lat)
        read_source = SRC_LATCH;
      else if (a == `NVCFG_ADDR)
        read_source = SRC_NVCFG;
      else if (in_array(a))
        read_source = SRC_ARRAY;
      else
        read_source = SRC_NONE;
    end
  endfunction

  // security forbids block and bulk entirely
  function mode_allowed;
    input [1:0] m;
    input       any_p;
    input       sec;
    begin
      case (m)
        `MODE_PROGRAM:   mode_allowed = 1'b1;
        `MODE_BYTE_ERA:  mode_allowed = 1'b1;
        `MODE_BLOCK_ERA: mode_allowed = ~sec;
        `MODE_BULK_ERA:  mode_allowed = ~(any_p | sec);
        default:         mode_allowed = 1'b0;
      endcase
    end
  endfunction

  // control register as a read sees it; upper bits read zero
  function [7:0] ctrl_view;
    input hv;
    input lat;
    input erlo;
    input erhi;
    begin
      ctrl_view = 8'h00;
      ctrl_view[`CTRL_HV_BIT]   = hv;
      ctrl_view[`CTRL_LAT_BIT]  = lat;
      ctrl_view[`CTRL_ERLO_BIT] = erlo;
      ctrl_view[`CTRL_ERHI_BIT] = erhi;
    end
  endfunction

  wire sec_now = sec_armed | ~config_shadow_reg[`CFG_SEC_BIT];
  wire is_cfg_a = (addr == `NVCFG_ADDR);
  // secured window drops out of the valid set
  wire arr_ok = in_array(addr) & ~(sec_now & in_secure(addr));
  // config byte is locked once secure
  wire cfg_ok = is_cfg_a & ~sec_now;
  wire valid_wr = wr & (arr_ok | cfg_ok);
  wire ctrl_wr = wr & (addr == `CTRL_ADDR);
  // refused control writes leave every bit untouched
  wire ctrl_take = ctrl_wr & (~latch_enable | have_valid);
  wire [1:0] mode = {erase_select_hi, erase_select_lo};

  ////////////////////////////////////////////////////////////////////
  // protection comes from the shadow only, never the live byte
  wire [3:0] prot = config_shadow_reg[3:0];
  wire       any_prot = |prot;
  wire [3:0] blk_sel = 4'h1 << lat_addr[8:7];
  wire [3:0] blk_hit;
  genvar     g;
  // one veto per 128-byte block
  generate
    for (g = 0; g < 4; g = g + 1) begin : prot_blk
      assign blk_hit[g] = prot[g] & blk_sel[g];
    end
  endgenerate
  // the config byte sits outside every block
  wire blk_prot = ~lat_cfg & (|blk_hit);
  wire op_ok = ~blk_prot & mode_allowed(mode, any_prot, sec_now);
  // low nine address bits index the array directly
  wire [8:0] rd_idx = addr[8:0];
  wire [2:0] rd_src = read_source(addr, latch_enable);

  ////////////////////////////////////////////////////////////////////
  // next control bits
  always @* begin
    next_hv_enable    = hv_enable;
    next_latch_enable = latch_enable;
    next_erase_hi     = erase_select_hi;
    next_erase_lo     = erase_select_lo;
    if (ctrl_take) begin
      // hv needs the latch and a captured valid write
      next_hv_enable = wdata[`CTRL_HV_BIT] & latch_enable & have_valid
                       & ~(~latch_enable & foreign_write);
      // latch cannot drop while hv was or stays set
      if (hv_enable || next_hv_enable)
        next_latch_enable = 1'b1;
      else
        next_latch_enable = wdata[`CTRL_LAT_BIT];
      // mode frozen once hv is up
      if (!hv_enable) begin
        next_erase_hi = wdata[`CTRL_ERHI_BIT];
        next_erase_lo = wdata[`CTRL_ERLO_BIT];
      end
    end
  end

  // control register
  always @(posedge clk_sys) begin
    if (rst) begin
      hv_enable       <= 1'b0;
      latch_enable    <= 1'b0;
      erase_select_hi <= 1'b0;
      erase_select_lo <= 1'b0;
    end else begin
      hv_enable       <= next_hv_enable;
      latch_enable    <= next_latch_enable;
      erase_select_hi <= next_erase_hi;
      erase_select_lo <= next_erase_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next capture state; a foreign write is flagged only while latch is clear
  always @* begin
    next_have_valid    = have_valid;
    next_foreign_write = foreign_write;
    if (latch_enable && valid_wr && !hv_enable)
      next_have_valid = 1'b1;
    else if (!latch_enable)
      next_have_valid = 1'b0;
    if (wr && !valid_wr && !ctrl_wr && !latch_enable)
      next_foreign_write = 1'b1;
    else if (ctrl_wr && wdata[`CTRL_LAT_BIT])
      next_foreign_write = 1'b0;
  end

  // capture of address and data; last valid write wins
  always @(posedge clk_sys) begin
    if (rst) begin
      have_valid    <= 1'b0;
      foreign_write <= 1'b0;
      lat_addr      <= 9'h000;
      lat_cfg       <= 1'b0;
      lat_data      <= 8'h00;
    end else begin
      have_valid    <= next_have_valid;
      foreign_write <= next_foreign_write;
      if (latch_enable && valid_wr && !hv_enable) begin
        lat_addr <= addr[8:0];
        lat_cfg  <= is_cfg_a;
        lat_data <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reload on reset release, or a config read with latch clear
  wire shadow_load = load_pend | (rd & is_cfg_a & ~latch_enable);

  // once secure the shadow changes again only on reset
  always @* begin
    next_shadow    = config_shadow_reg;
    next_sec_armed = sec_armed;
    if (shadow_load && !sec_now)
      next_shadow = nonvolatile_config_byte;
    if (!config_shadow_reg[`CFG_SEC_BIT])
      next_sec_armed = 1'b1;
  end

  // shadow register
  always @(posedge clk_sys) begin
    if (rst) begin
      load_pend         <= 1'b1;
      sec_armed         <= 1'b0;
      config_shadow_reg <= 8'hff;
    end else begin
      load_pend         <= 1'b0;
      sec_armed         <= next_sec_armed;
      config_shadow_reg <= next_shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // high voltage: pump follows bit; array gets it if op allowed
  always @(posedge clk_sys) begin
    if (rst) begin
      pump_on    <= 1'b0;
      hv_applied <= 1'b0;
      hv_q       <= 1'b0;
    end else begin
      pump_on    <= hv_enable;
      hv_applied <= hv_enable & op_ok;
      hv_q       <= hv_enable;
    end
  end

  // security status; registered so the pin never glitches
  always @(posedge clk_sys) begin
    if (rst) begin
      secured <= 1'b0;
    end else begin
      secured <= sec_now;
    end
  end

  // one pulse per hv rise, so a held bit cannot repeat the op
  wire hv_rise = hv_enable & ~hv_q;
  wire apply = hv_rise & op_ok;

  nvm_array #(
    .DEPTH (512)
  ) u_array (
    .clk_sys       (clk_sys),
    .apply         (apply),
    .mode          (mode),
    .addr          (lat_addr),
    .is_cfg        (lat_cfg),
    .keep_mask_blk ({5'h00, prot}),
    .wdata         (lat_data),
    .raddr         (rd_idx),
    .rdata         (arr_rdata),
    .cfg_byte      (nonvolatile_config_byte)
  );

  ////////////////////////////////////////////////////////////////////
  // answer registered so rdata comes straight from a flop;
  // the array read is combinational to keep one cycle latency
  always @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (rd_src)
        SRC_CTRL:  rdata <= ctrl_view(hv_enable, latch_enable,
                                      erase_select_lo, erase_select_hi);
        SRC_SHAD:  rdata <= config_shadow_reg;
        SRC_LATCH: rdata <= lat_data;
        SRC_NVCFG: rdata <= nonvolatile_config_byte;
        SRC_ARRAY: rdata <= arr_rdata;
        default:   rdata <= 8'h00;
      endcase
    end else begin
      // answer stands for one cycle only
      rdata <= 8'h00;
    end
  end
endmodule // nvm_ctrl

// >>> nvm_ctrl_chk.sv
// Purpose: port checker for the eeprom control block
// Assumes: pump and high-voltage status lag a control write by 1-2 clocks
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_ctrl_chk (
  input wire        clk_sys,
  input wire        rst,
  input wire [15:0] addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  input wire        pump_on,
  input wire        hv_applied,
  input wire        secured
);
  // control register write seen this cycle
  wire ctl_wr = wr && addr == `CTRL_ADDR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata driven outside answer cycle");
  a_hv_needs_pump: assert property (hv_applied |-> pump_on)
    else $error("voltage on array without pump");
  a_pump_by_ctrl: assert property ($rose(pump_on) |->
    ($past(ctl_wr) && $past(wdata[0])) || $past(ctl_wr, 2))
    else $error("pump started without control write");
  a_pump_steady: assert property (!ctl_wr ##1 !ctl_wr |=> $stable(pump_on))
    else $error("pump changed with no control write");
  a_hv_clear: assert property (ctl_wr && !wdata[0] |-> ##[1:2] !pump_on)
    else $error("pump still on after clearing write");
  a_latch_hold: assert property (pump_on && ctl_wr && wdata[0] &&
    !$past(ctl_wr) |=> pump_on)
    else $error("pump dropped while high voltage held");
  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> !pump_on && !hv_applied)
    else $error("pump or voltage on during reset");
  a_secure_sticky: assert property (secured |=> secured)
    else $error("security dropped");
  // main scenarios reached
  cover property ($rose(pump_on));
  cover property ($rose(secured));
  cover property (rd ##1 rdata != 8'h00);
endmodule // nvm_ctrl_chk

bind nvm_ctrl nvm_ctrl_chk i_nvm_ctrl_chk (.clk_sys(clk_sys), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pump_on(pump_on), .hv_applied(hv_applied), .secured(secured));

// >>> cpu_bus.sv
// Purpose: cpu bus master model for the eeprom control block
// Assumes: one strobe per access, read data in the cycle after
// Notes:   an idle cycle follows every access
`timescale 1ns/1ps
module cpu_bus (
  input  wire        clk_sys,
  input  wire [7:0]  rdata,
  output reg  [15:0] addr,
  output reg  [7:0]  wdata,
  output reg         wr,
  output reg         rd
);
  // bus idle from time zero
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // write strobe held until the taking edge
  task wb(input [15:0] a, input [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // answer only stands in the cycle after the strobe
  task rb(input [15:0] a, output [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // cpu_bus

// >>> eeprom_program_erase_control_bench.sv
// Purpose: self-checking bench for the eeprom control block
// Assumes: config byte starts erased, array starts erased
// Notes:   random programs are each undone by a bulk erase
`timescale 1ns/1ps
`include "nvm_map.vh"
module eeprom_program_erase_control_bench;
  reg         clk_sys;
  reg         rst = 1'b1;
  wire [15:0] addr;
  wire [7:0]  wdata;
  wire [7:0]  rdata;
  wire        wr;
  wire        rd;
  wire        pump_on;
  wire        hv_applied;
  wire        secured;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     i;
  reg [31:0]  seed = 32'h87e9;
  reg [15:0]  ra;
  reg [7:0]   v;
  nvm_ctrl i_nvm_ctrl (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pump_on(pump_on),
    .hv_applied(hv_applied), .secured(secured));
  cpu_bus i_cpu_bus (.clk_sys(clk_sys), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  ////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ck(input string n, input [7:0] e, input [7:0] s);
    comparisons = comparisons + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task w(input [15:0] a, input [7:0] d); i_cpu_bus.wb(a, d); endtask
  task ctl(input [7:0] d); i_cpu_bus.wb(`CTRL_ADDR, d); endtask
  task rdc(input [15:0] a, input [7:0] e);
    i_cpu_bus.rb(a, v);
    ck("rdata", e, v);
  endtask
  task settle; repeat (2) @(posedge clk_sys); #1; endtask
  task rs; rst <= 1'b1; repeat (3) @(posedge clk_sys); rst <= 1'b0; endtask
  // valid write then latch clear, for sequences left hanging
  task unlock; w(16'h0801, 8'hff); ctl(8'h00); endtask
  // full program or erase sequence, decoy write first
  task op(input [1:0] m, input [15:0] a, input [7:0] d, input hv);
    ctl({4'h0, m, 2'b10});
    w(a ^ 16'h0004, ~d);
    w(a, d);
    ctl({4'h0, m, 2'b11});
    settle;
    ck("hv_applied", {7'h00, hv}, hv_applied);
    ctl({4'h0, m, 2'b01});
    ctl({4'h0, m, 2'b00});
    settle;
    ck("pump_on", 8'h00, pump_on);
    if (hv && a < 16'h1000) rdc(a ^ 16'h0002, d);
    ctl(8'h00);
  endtask
  // watchdog sized well past the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count = fail_count + 1;
    stop_test;
  end
  ////////////////////////////////
  initial begin
    rs;
    settle;
    ck("secured", 8'h00, secured);
    op(0, `NVCFG_ADDR, 8'hf0, 1);
    rdc(`NVCFG_ADDR, 8'hf0);
    rdc(`SHADOW_ADDR, 8'hf0);
    w(16'h0040, 8'h11);
    ctl(8'h01);
    settle;
    ck("pump_on", 8'h00, pump_on);
    ctl(8'h02);
    ctl(8'h03);
    settle;
    ck("pump_on", 8'h00, pump_on);
    unlock;
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      ra = 16'h0800 + {7'h00, seed[8:0]};
      op(0, ra, seed[16:9], 1);
      rdc(ra, seed[16:9]);
      op(3, ra, 8'h00, 1);
      rdc(ra, 8'hff);
    end
    op(0, 16'h0801, 8'h00, 1);
    op(0, 16'h0985, 8'h00, 1);
    op(0, 16'h08f5, 8'h5a, 1);
    op(1, 16'h0801, 8'h00, 1);
    rdc(16'h0801, 8'hff);
    rdc(16'h0985, 8'h00);
    op(2, 16'h09ff, 8'h00, 1);
    rdc(16'h0985, 8'hff);
    rdc(16'h08f5, 8'h5a);
    rdc(`NVCFG_ADDR, 8'hf0);
    op(0, 16'h0801, 8'h00, 1);
    op(0, 16'h0985, 8'h00, 1);
    op(1, `NVCFG_ADDR, 8'h00, 1);
    op(0, `NVCFG_ADDR, 8'he8, 1);
    rdc(`NVCFG_ADDR, 8'he8);
    settle;
    ck("secured", 8'h01, secured);
    op(0, 16'h08f5, 8'h00, 0);
    unlock;
    op(2, 16'h0801, 8'h00, 0);
    op(3, 16'h0801, 8'h00, 0);
    op(1, `NVCFG_ADDR, 8'h00, 0);
    unlock;
    op(1, 16'h0985, 8'h00, 0);
    rdc(16'h0985, 8'h00);
    op(1, 16'h0801, 8'h00, 1);
    rdc(16'h0801, 8'hff);
    rdc(16'h08f5, 8'h5a);
    rs;
    settle;
    ck("secured", 8'h01, secured);
    stop_test;
  end
endmodule // eeprom_program_erase_control_bench
